// ===== rtl/nosc_top.sv
// Numerically controlled oscillator with phase accumulator and pulse/toggle output
//
// Behaviour
// - 20-bit accumulator, read and written through three byte registers.
// - Each selected input clock rising edge: accumulator plus buffered increment.
// - Adder carry out is the raw overflow event.
// - Six clock sources chosen by a 3-bit select field.
// - Select 000 system, 001 fast oscillator, 010-101 logic cells, rest reserved.
// - 20-bit increment stored low, high, upper bytes.
// - Enabled: low byte write loads buffer on second input clock edge.
// - Increment double buffered in hidden registers.
// - Disabled: increment writes reach the buffer immediately.
// - Toggle mode inverts output each overflow.
// - Pulse-mode bit zero selects toggle, one selects pulse mode.
// - Pulse mode: output active after overflow for selected periods, then inactive.
// - Pulse width from 3-bit field, ignored in toggle mode.
// - Width field n gives 2^n input clock periods.
// - Polarity bit inverts the output as last stage.
// - Polarity change with interrupts enabled raises the flag.
// - Each overflow sets the interrupt flag.
// - Request only when enable, irq, peripheral and global enables set.
// - Flag stays set until software clears it.
// - Reset clears every register to zero.
// - Keeps running in sleep on its own input clock; here all state is clocked by the system clock instead.
// - Enabled with fast oscillator selected: request it to stay running.
// - Read-only status bit shows current output.
//
// Register map on the plain port, by index
//   0  control: enable 7, output status 5 read only, polarity 4, pulse mode 0
//   1  clock control: pulse width 7:5, source select 2:0
//   2  accumulator bits 7:0
//   3  accumulator bits 15:8
//   4  accumulator bits 19:16 in the low nibble
//   5  increment bits 7:0; an enabled write here commits the whole word
//   6  increment bits 15:8
//   7  increment bits 19:16 in the low nibble
//   8  interrupt flag in bit 0; writing 0 clears it, writing 1 sets it
//   9  interrupt enables: global 2, peripheral 1, module 0
//   Other indices read zero and drop writes; spare bits read zero.
//
// Limitations
//   Foreign sources are seen two system clocks late through the
//   synchroniser, so a source must run well below half the system clock.
//   Pulse widths longer than the overflow interval give no defined output.
//   An accumulator byte written while running replaces that byte of the step.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "nosc_cfg.svh"
module nosc_top (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Register port
  input  wire logic [`NOSC_ADDR_W-1:0] addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output      logic [7:0]              rdata,
  // Clock sources from outside this domain
  input  wire logic                    internal_fast_oscillator,
  input  wire logic                    logic_cell_one_output,
  input  wire logic                    logic_cell_two_output,
  input  wire logic                    logic_cell_three_output,
  input  wire logic                    logic_cell_four_output,
  // Synthesized output and requests
  output      logic                    synth_out,
  output      logic                    irq_req,
  output      logic                    keep_fast_osc
);

  nosc_pkg::nosc_state_type s_q;
  nosc_pkg::nosc_state_type s_d;

  logic [4:0]              ext_clk;
  logic                    sel_lvl;
  logic                    tick;
  logic [`NOSC_ACC_W:0]    sum;
  logic                    carry;
  logic                    ints_on;
  logic [7:0]              width;

  assign ext_clk = {logic_cell_four_output, logic_cell_three_output,
                    logic_cell_two_output, logic_cell_one_output,
                    internal_fast_oscillator};

  // Level of the selected, already synchronised source
  always_comb begin
    sel_lvl = 1'b0;
    if (s_q.cks >= `NOSC_CKS_HFOSC && s_q.cks <= `NOSC_CKS_LC4) begin
      sel_lvl = s_q.sync2[s_q.cks - `NOSC_CKS_HFOSC];
    end
  end

  // Input clock tick: every cycle on system clock, else a synced rising edge
  assign tick = (s_q.cks == `NOSC_CKS_SYS) ? 1'b1 : (sel_lvl & ~s_q.sel_prev);
  // Adder runs free of the clock; result used only on a tick
  assign sum     = {1'b0, s_q.acc} + {1'b0, s_q.incbuf};
  assign carry   = s_q.en & tick & sum[`NOSC_ACC_W];
  // All four enables; arms the polarity interrupt
  assign ints_on = s_q.en & s_q.ie & s_q.pie & s_q.global_irq_enable;
  // 2^n periods; one tick already spent at the start
  assign width   = (8'h01 << s_q.pws) - 8'h01;

  // Next state
  always_comb begin
    s_d          = s_q;
    // Two flops on every foreign source; only the second is looked at
    s_d.sync1    = ext_clk;
    s_d.sync2    = s_q.sync1;
    s_d.sel_prev = sel_lvl;

    // Accumulator, steps on each source clock tick while enabled
    if (s_q.en && tick) begin
      s_d.acc = sum[`NOSC_ACC_W-1:0];
    end

    // Delayed buffer load after a low byte write
    if (s_q.pend != 2'h0 && tick) begin
      s_d.pend = s_q.pend - 2'h1;
      if (s_q.pend == 2'h1) begin
        s_d.incbuf = s_q.inc;
      end
    end

    // Output modes
    if (!s_q.en) begin
      s_d.raw  = 1'b0;
      s_d.wcnt = `NOSC_ZERO8;
    end else if (!s_q.pfm) begin
      if (carry) begin
        s_d.raw = ~s_q.raw;
      end
    end else if (carry) begin
      s_d.raw  = 1'b1;
      s_d.wcnt = width;
    end else if (tick && s_q.raw) begin
      if (s_q.wcnt == `NOSC_ZERO8) begin
        s_d.raw = 1'b0;
      end else begin
        s_d.wcnt = s_q.wcnt - 8'h01;
      end
    end

    // Register writes
    if (wr_stb) begin
      case (addr)
        `NOSC_OFS_CON: begin
          s_d.en  = wdata[`NOSC_CON_EN];
          s_d.pol = wdata[`NOSC_CON_POL];
          s_d.pfm = wdata[`NOSC_CON_PFM];
        end
        `NOSC_OFS_CLK: begin
          s_d.pws = wdata[`NOSC_CLK_PWS_HI:`NOSC_CLK_PWS_LO];
          s_d.cks = wdata[`NOSC_CLK_CKS_HI:`NOSC_CLK_CKS_LO];
          // A new source is never seen as an edge on its first cycle
          s_d.sel_prev = 1'b1;
        end
        `NOSC_OFS_ACCL: s_d.acc[7:0]   = wdata;
        `NOSC_OFS_ACCH: s_d.acc[15:8]  = wdata;
        `NOSC_OFS_ACCU: s_d.acc[19:16] = wdata[3:0];
        `NOSC_OFS_INCL: begin
          s_d.inc[7:0] = wdata;
          s_d.pend     = s_q.en ? `NOSC_LOAD_DELAY : 2'h0;
        end
        `NOSC_OFS_INCH: s_d.inc[15:8]  = wdata;
        `NOSC_OFS_INCU: s_d.inc[19:16] = wdata[3:0];
        `NOSC_OFS_IRQF: s_d.flag = wdata[`NOSC_IRQF_FLAG];
        `NOSC_OFS_IRQE: begin
          s_d.ie  = wdata[`NOSC_IRQE_IE];
          s_d.pie = wdata[`NOSC_IRQE_PIE];
          s_d.global_irq_enable = wdata[`NOSC_IRQE_GIE];
        end
        default: ;
      endcase
      // Disabled module: buffer follows the increment at once
      if (!s_q.en && addr >= `NOSC_OFS_INCL && addr <= `NOSC_OFS_INCU) begin
        s_d.incbuf = s_d.inc;
      end
    end

    // Polarity as last stage; status follows it
    s_d.out = s_d.raw ^ s_d.pol;

    // Hardware set wins over a software clear in the same cycle
    if (carry) begin
      s_d.flag = 1'b1;
    end
    if (ints_on && s_d.pol != s_q.pol && s_d.out != s_q.out) begin
      s_d.flag = 1'b1;
    end

    // Request and keep levels register with the state they follow
    s_d.irq  = s_d.flag & s_d.en & s_d.ie & s_d.pie & s_d.global_irq_enable;
    s_d.keep = s_d.en & (s_d.cks == `NOSC_CKS_HFOSC);

    // Read data valid the cycle after the strobe only
    s_d.rdata = `NOSC_ZERO8;
    if (rd_stb) begin
      case (addr)
        `NOSC_OFS_CON: s_d.rdata = {s_q.en, 1'b0, s_q.out, s_q.pol, 3'h0, s_q.pfm};
        `NOSC_OFS_CLK: s_d.rdata = {s_q.pws, 2'h0, s_q.cks};
        `NOSC_OFS_ACCL: s_d.rdata = s_q.acc[7:0];
        `NOSC_OFS_ACCH: s_d.rdata = s_q.acc[15:8];
        `NOSC_OFS_ACCU: s_d.rdata = {4'h0, s_q.acc[19:16]};
        `NOSC_OFS_INCL: s_d.rdata = s_q.inc[7:0];
        `NOSC_OFS_INCH: s_d.rdata = s_q.inc[15:8];
        `NOSC_OFS_INCU: s_d.rdata = {4'h0, s_q.inc[19:16]};
        `NOSC_OFS_IRQF: s_d.rdata = {7'h00, s_q.flag};
        `NOSC_OFS_IRQE: s_d.rdata = {5'h00, s_q.global_irq_enable, s_q.pie, s_q.ie};
        default:        s_d.rdata = `NOSC_ZERO8;
      endcase
    end
  end

  // State register; everything clears on reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flops
  assign rdata         = s_q.rdata;
  assign synth_out     = s_q.out;
  assign irq_req       = s_q.irq;
  assign keep_fast_osc = s_q.keep;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence low_write_enabled;
    wr_stb && addr == `NOSC_OFS_INCL && s_q.en;
  endsequence

  sequence pulse_armed;
    carry && s_q.pfm;
  endsequence

  // Buffer load step: second tick after an enabled low byte write
  sequence load_due;
    s_q.pend == 2'h1 && tick && !wr_stb;
  endsequence

  // Pulse in progress on an input tick, no new overflow
  sequence pulse_ticking;
    s_q.en && s_q.pfm && s_q.raw && tick && !carry && !wr_stb;
  endsequence

  // Software turns polarity over while interrupts are armed
  sequence pol_flip;
    ints_on && wr_stb && addr == `NOSC_OFS_CON && wdata[`NOSC_CON_POL] != s_q.pol;
  endsequence

  a_acc_step: assert property (
    (s_q.en && tick && !wr_stb) |=> s_q.acc == $past(sum[`NOSC_ACC_W-1:0]))
    else $error("accumulator did not step by the increment");

  a_carry_flag: assert property (carry |=> s_q.flag)
    else $error("overflow did not set the flag");

  a_irq_gate: assert property (
    ##1 irq_req == $past(s_d.flag & s_d.en & s_d.ie & s_d.pie & s_d.global_irq_enable))
    else $error("interrupt request not gated by all enables");

  a_inc_direct: assert property (
    (wr_stb && !s_q.en && addr == `NOSC_OFS_INCH) |=> s_q.incbuf[15:8] == $past(wdata))
    else $error("disabled increment write not copied to buffer");

  a_inc_pending: assert property (
    low_write_enabled |=> s_q.pend == `NOSC_LOAD_DELAY)
    else $error("low byte write did not arm the buffer load");

  a_toggle_mode: assert property (
    (carry && !s_q.pfm && !wr_stb) |=> s_q.raw != $past(s_q.raw))
    else $error("toggle mode did not invert on overflow");

  a_pulse_start: assert property (
    (pulse_armed and !wr_stb) |=> (s_q.raw && s_q.wcnt == $past(width)))
    else $error("pulse did not start with selected width");

  a_polarity_out: assert property (synth_out == (s_q.raw ^ s_q.pol))
    else $error("output not raw level through polarity");

  a_keep_osc: assert property (
    ##1 keep_fast_osc == (s_q.en && s_q.cks == `NOSC_CKS_HFOSC))
    else $error("fast oscillator keep request wrong");

  a_flag_hold: assert property (
    (s_q.flag && !(wr_stb && addr == `NOSC_OFS_IRQF)) |=> s_q.flag)
    else $error("flag dropped without software clear");

  // Increment buffer: loads at the armed tick, or at once on a disabled write, otherwise holds
  a_buf_load: assert property (load_due |=> s_q.incbuf == $past(s_q.inc))
    else $error("increment buffer not loaded at the second tick");

  a_buf_hold: assert property (
    (s_q.en && s_q.pend == 2'h0) |=> s_q.incbuf == $past(s_q.incbuf))
    else $error("increment buffer changed while running without a load");

  a_inc_low_direct: assert property (
    (wr_stb && !s_q.en && addr == `NOSC_OFS_INCL) |=>
      (s_q.incbuf[7:0] == $past(wdata) && s_q.pend == 2'h0))
    else $error("disabled low byte write not copied to buffer");

  a_pend_step: assert property (
    (s_q.pend == `NOSC_LOAD_DELAY && tick && !wr_stb) |=> s_q.pend == 2'h1)
    else $error("buffer load countdown did not step on a tick");

  // Disabled module: accumulator stands still, raw level held low; enabled toggle mode holds its level between overflows
  a_acc_frozen: assert property (
    (!s_q.en && !wr_stb) |=> s_q.acc == $past(s_q.acc))
    else $error("accumulator moved while disabled");

  a_raw_idle: assert property (!s_q.en |=> !s_q.raw)
    else $error("raw output active while disabled");

  a_carry_off: assert property (!s_q.en |-> !carry)
    else $error("overflow event while disabled");

  a_toggle_quiet: assert property (
    (s_q.en && !s_q.pfm && !carry && !wr_stb) |=> s_q.raw == $past(s_q.raw))
    else $error("toggle output moved without an overflow");

  // Pulse body: count down per tick, drop at zero
  a_pulse_count: assert property (
    (pulse_ticking and s_q.wcnt != `NOSC_ZERO8) |=> s_q.wcnt == $past(s_q.wcnt) - 8'h01)
    else $error("pulse width counter did not step");

  a_pulse_end: assert property (
    (pulse_ticking and s_q.wcnt == `NOSC_ZERO8) |=> !s_q.raw)
    else $error("pulse did not end after its width");

  // Interrupt side: polarity event, software clear, gating; fast oscillator keep request off while disabled
  a_pol_irq: assert property (
    pol_flip |=> (s_q.out == $past(s_q.out) || s_q.flag))
    else $error("polarity change of the output did not set the flag");

  a_flag_clear: assert property (
    (wr_stb && addr == `NOSC_OFS_IRQF && !wdata[`NOSC_IRQF_FLAG] && !carry) |=> !s_q.flag)
    else $error("software clear of the flag had no effect");

  a_flag_set_wins: assert property (
    (carry && wr_stb && addr == `NOSC_OFS_IRQF) |=> s_q.flag)
    else $error("software clear beat an overflow in the same cycle");

  a_irq_off: assert property (!s_q.en |-> !irq_req)
    else $error("interrupt request while disabled");

  a_keep_off: assert property (!s_q.en |-> !keep_fast_osc)
    else $error("fast oscillator kept while disabled");

  // Input clock path
  a_reserved_src: assert property ((s_q.cks > `NOSC_CKS_LC4) |-> !tick)
    else $error("reserved source produced an input tick");

  a_sync_chain: assert property (s_q.sync2 == $past(s_q.sync1))
    else $error("source synchroniser skipped a stage");

  // Read port: data only in the cycle after the strobe
  a_read_idle: assert property (!rd_stb |=> rdata == `NOSC_ZERO8)
    else $error("read data present without a read strobe");

  a_acc_read: assert property (
    (rd_stb && addr == `NOSC_OFS_ACCL) |=> rdata == $past(s_q.acc[7:0]))
    else $error("accumulator low byte read back wrong");

  a_status_read: assert property (
    (rd_stb && addr == `NOSC_OFS_CON) |=> rdata[`NOSC_CON_OUT] == $past(s_q.out))
    else $error("status bit does not show the output");

endmodule : nosc_top

// ===== pkg/nosc_cfg.svh
// Register offsets, field positions and constants of the oscillator block
`ifndef NOSC_CFG_SVH
`define NOSC_CFG_SVH
// Register offsets (byte index on the plain port)
`define NOSC_ADDR_W        4
`define NOSC_OFS_CON       4'h0
`define NOSC_OFS_CLK       4'h1
`define NOSC_OFS_ACCL      4'h2
`define NOSC_OFS_ACCH      4'h3
`define NOSC_OFS_ACCU      4'h4
`define NOSC_OFS_INCL      4'h5
`define NOSC_OFS_INCH      4'h6
`define NOSC_OFS_INCU      4'h7
`define NOSC_OFS_IRQF      4'h8
`define NOSC_OFS_IRQE      4'h9
// Control register fields
`define NOSC_CON_EN        7
`define NOSC_CON_OUT       5
`define NOSC_CON_POL       4
`define NOSC_CON_PFM       0
// Clock control fields
`define NOSC_CLK_PWS_HI    7
`define NOSC_CLK_PWS_LO    5
`define NOSC_CLK_CKS_HI    2
`define NOSC_CLK_CKS_LO    0
// Interrupt enable fields
`define NOSC_IRQE_IE       0
`define NOSC_IRQE_PIE      1
`define NOSC_IRQE_GIE      2
`define NOSC_IRQF_FLAG     0
// Clock select codes
`define NOSC_CKS_SYS       3'h0
`define NOSC_CKS_HFOSC     3'h1
`define NOSC_CKS_LC1       3'h2
`define NOSC_CKS_LC4       3'h5
// Widths and counts
`define NOSC_ACC_W         20
`define NOSC_EXT_CLKS      5
`define NOSC_LOAD_DELAY    2'h2
`define NOSC_ZERO8         8'h00
`endif

// ===== pkg/nosc_pkg.sv
// Types of the oscillator block
package nosc_pkg;
  // Complete state of the oscillator top
  typedef struct packed {
    logic        en;
    logic        pol;
    logic        pfm;
    logic [2:0]  pws;
    logic [2:0]  cks;
    logic [19:0] acc;
    logic [19:0] inc;
    logic [19:0] incbuf;
    logic [1:0]  pend;
    logic        raw;
    logic [7:0]  wcnt;
    logic        flag;
    logic        ie;
    logic        pie;
    logic        global_irq_enable;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        sel_prev;
    logic        out;
    logic        irq;
    logic        keep;
    logic [7:0]  rdata;
  } nosc_state_type;
endpackage : nosc_pkg

// ===== sim/nosc_sink.sv
// Consumer of the synthesized output: counts rising edges and active cycles
`timescale 1ns/1ps
module nosc_sink (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Observed level and window restart
  input  wire logic level,
  input  wire logic clr,
  // Counts since the last restart
  output      int   rises,
  output      int   highs
);
  logic prev_q;

  // Samples on the system clock, like a peripheral sitting on the same clock
  always @(posedge clock or negedge nrst) begin
    if (!nrst || clr) begin
      rises <= 0;
      highs <= 0;
    end else begin
      rises <= rises + int'(level && !prev_q);
      highs <= highs + int'(level);
    end
    prev_q <= nrst ? level : 1'b0;
  end
endmodule : nosc_sink

// ===== sim/numeric_osc_freq_synth_tb_top.sv
// Bench for the oscillator block: registers, clock sources, modes and interrupt
`timescale 1ns/1ps
`include "nosc_cfg.svh"
module numeric_osc_freq_synth_tb_top;
  logic                    clock, nrst, wr_stb, rd_stb, clr;
  logic [`NOSC_ADDR_W-1:0] addr;
  logic [7:0]              wdata, rdata, lfsr_q;
  logic [7:0]              div_q = 8'h00;
  logic                    synth_out, irq_req, keep_fast_osc;
  int                      checks, rises, highs, e;
  int                      bad_count = 0;
  int                      cycles = 0;
  int                      exp_reg [16];
  int                      per [8] = '{1, 4, 8, 16, 32, 64, 0, 0};

  nosc_top dut_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .internal_fast_oscillator(div_q[1]),
    .logic_cell_one_output(div_q[2]), .logic_cell_two_output(div_q[3]),
    .logic_cell_three_output(div_q[4]), .logic_cell_four_output(div_q[5]),
    .synth_out(synth_out), .irq_req(irq_req), .keep_fast_osc(keep_fast_osc));
  nosc_sink sink_u (.clock(clock), .nrst(nrst), .level(synth_out), .clr(clr),
    .rises(rises), .highs(highs));

  // Clock; the slow sources are counter bits, so each has an exact period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    div_q <= div_q + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // Bits compared per register; control status bit 5 is expected from the rules
  function automatic int mask(input int a);
    case (a)
      0: return 8'hB1;
      1: return 8'hE7;
      4, 7: return 8'h0F;
      8: return 8'h01;
      9: return 8'h07;
      default: return 8'hFF;
    endcase
  endfunction : mask
  // Toggle mode rising edges: half the carries of ticks * increment
  function automatic int toggles(input int ticks, input int inc);
    return ((ticks * inc) >> 20) / 2;
  endfunction : toggles

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a[3:0];
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
    if (a < 10) exp_reg[a] = d;
  endtask : wr
  task automatic rchk(input int a);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a[3:0];
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 check("register", 32'(exp_reg[a] & mask(a)), {24'h0, rdata & 8'(mask(a))});
  endtask : rchk
  // Settle after a change, then count over a window of system clocks
  task automatic measure(input int win);
    repeat (64) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (win) @(posedge clock);
    #1;
  endtask : measure
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    nrst = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    clr = 1'b0;
    addr = '0;
    wdata = 8'h00;
    lfsr_q = 8'h10;
    checks = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 11; a++) rchk(a);
    $display("test reset done");
    // Random bytes into accumulator and increment while stopped
    for (int a = 2; a < 8; a++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(a, lfsr_q);
      rchk(a);
    end
    $display("test registers done");
    // Upper and high before low; disabled so the buffer loads at once
    wr(7, 8'h08);
    wr(6, 8'h00);
    wr(5, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(1, 8'(c));
      wr(0, 8'h80);
      measure(512);
      e = per[c] == 0 ? 0 : toggles(512 / per[c], 32'h80000);
      check("rises", e, rises);
      check("keep", c == 1, keep_fast_osc);
    end
    exp_reg[8] = 1;
    rchk(8);
    check("irq", 0, irq_req);
    wr(9, 8'h07);
    repeat (3) @(posedge clock);
    #1 check("irq", 1, irq_req);
    // Polarity turned over with interrupts armed and no ticks: flag again
    wr(8, 8'h00);
    rchk(8);
    wr(0, 8'h90);
    exp_reg[8] = 1;
    rchk(8);
    wr(8, 8'h00);
    rchk(8);
    check("irq", 0, irq_req);
    wr(9, 8'h00);
    $display("test sources done");
    // Pulse widths stay below the 16-tick carry interval
    wr(7, 8'h01);
    wr(6, 8'h00);
    wr(5, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 4; w++) begin
        wr(1, 8'(w << 5));
        wr(0, 8'(8'h81 | (p << 4)));
        measure(64);
        e = ((64 * 32'h10000) >> 20) << w;
        check("highs", p ? 64 - e : e, highs);
      end
    end
    $display("test pulse done");
    // Running: upper byte alone must not reach the adder
    wr(0, 8'h80);
    wr(1, 8'h00);
    wr(7, 8'h02);
    measure(64);
    check("rises", toggles(64, 32'h10000), rises);
    wr(6, 8'h00);
    wr(5, 8'h00);
    measure(64);
    check("rises", toggles(64, 32'h20000), rises);
    wr(0, 8'h10);
    repeat (4) @(posedge clock);
    #1 check("level", 1, synth_out);
    exp_reg[0] = 8'h30;
    rchk(0);
    $display("test buffer done");
    complete_run();
  end
endmodule : numeric_osc_freq_synth_tb_top
